/* File: src/sdi_serial_dac_input.sv */
`timescale 1ns/1ps
`include "sdi_cfg.svh"
module sdi_serial_dac_input (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_sclk,
  input wire logic i_frame_n,
  input wire logic i_serial_in,
  input wire logic i_latch_load_n,
  output sdi_pkg::sdi_code_s o_code,
  output logic o_update
);
  // link domain: runs on the inverted serial clock (falling edges)
  logic [`SDI_WORD_BITS-1:0] sh_q, sh_d;
  logic [`SDI_CNT_W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [`SDI_WORD_BITS-1:0] word_q, word_d;
  logic frame_seen_q;

  // frame high holds frame_seen_q and done_q clear so the next frame's count restarts at 1
  always_ff @(negedge i_sclk or posedge i_frame_n) begin
    if (i_frame_n) begin
      frame_seen_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      frame_seen_q <= 1'b1;
      done_q <= done_d;
    end
  end

  always_comb begin
    sh_d = {sh_q[`SDI_WORD_BITS-2:0], i_serial_in};
    cnt_d = frame_seen_q ? cnt_q + `SDI_CNT_W'(1) : `SDI_CNT_W'(1);
    done_d = done_q;
    word_d = word_q;
    if (cnt_d == `SDI_CNT_W'(`SDI_WORD_BITS)) begin
      done_d = 1'b1;
      word_d = sh_d;
    end
  end

  // no reset pin exists on the link; frame low gates every edge
  always_ff @(negedge i_sclk) begin
    if (!i_frame_n) begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
    end
  end

  // system domain
  logic [1:0] done_sync_q, done_sync_d;
  logic [1:0] ld_sync_q, ld_sync_d;
  logic ld_prev_q, ld_prev_d;
  logic taken_q, taken_d;
  logic word_rdy_q, word_rdy_d;
  logic [`SDI_WORD_BITS-1:0] cap_q, cap_d;
  sdi_pkg::sdi_code_s code_q, code_d;
  logic upd_q, upd_d;
  logic done_lvl, word_evt, ld_fall, ld_low;
  logic [`SDI_CODE_BITS-1:0] cap_code;

  always_comb begin
    done_sync_d = {done_sync_q[0], done_q};
    ld_sync_d = {ld_sync_q[0], i_latch_load_n};
    done_lvl = done_sync_q[1];
    // one capture per frame; an unknown level before the first frame fires once after reset if it comes up high
    word_evt = done_lvl & ~taken_q;
    ld_low = ~ld_sync_q[1];
    ld_fall = ld_prev_q & ld_low;
    ld_prev_d = ~ld_low;
    cap_code = cap_q[`SDI_CODE_BITS-1:0];
    cap_d = cap_q;
    taken_d = taken_q;
    word_rdy_d = word_rdy_q;
    code_d = code_q;
    upd_d = 1'b0;
    if (!done_lvl) begin
      taken_d = 1'b0;
    end
    if (word_rdy_q && (ld_fall || ld_low)) begin
      code_d.code = cap_code;
      code_d.neg_fs = (cap_code == `SDI_CODE_NEG_FS);
      code_d.pos_fs = (cap_code == `SDI_CODE_POS_FS);
      upd_d = 1'b1;
      word_rdy_d = 1'b0;
    end
    if (word_evt) begin
      // word stays put in the link domain until the next frame's 16th edge
      cap_d = word_q;
      word_rdy_d = 1'b1;
      taken_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      done_sync_q <= 2'h0;
      ld_sync_q <= 2'h3;
      ld_prev_q <= 1'b1;
      taken_q <= 1'b0;
      word_rdy_q <= 1'b0;
      cap_q <= {`SDI_WORD_BITS{1'b0}};
      code_q <= '{code: `SDI_CODE_RST, neg_fs: 1'b0, pos_fs: 1'b0};
      upd_q <= 1'b0;
    end else begin
      done_sync_q <= done_sync_d;
      ld_sync_q <= ld_sync_d;
      ld_prev_q <= ld_prev_d;
      taken_q <= taken_d;
      word_rdy_q <= word_rdy_d;
      cap_q <= cap_d;
      code_q <= code_d;
      upd_q <= upd_d;
    end
  end

  assign o_code = code_q;
  assign o_update = upd_q;

  // system-domain checks
  sequence s_strobe_fall;
    word_rdy_q && ld_fall;
  endsequence

  sequence s_load_pulse;
    upd_q ##1 !upd_q;
  endsequence

  sequence s_word_seen;
    word_evt ##1 word_rdy_q;
  endsequence

  a_update_has_word: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) upd_q |-> $past(word_rdy_q))
    else $error("update without a full word");

  a_code_from_word: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) upd_q |-> code_q.code == $past(cap_code))
    else $error("latched code wrong");

  a_negfs_flag: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) o_code.neg_fs == (o_code.code == `SDI_CODE_NEG_FS))
    else $error("neg full scale flag");

  a_posfs_flag: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) o_code.pos_fs == (o_code.code == `SDI_CODE_POS_FS))
    else $error("pos full scale flag");

  a_bipolar_sign: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) o_code.pos_fs |-> !o_code.code[`SDI_CODE_BITS-1])
    else $error("positive code has sign bit");

  a_code_holds: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) !upd_q |-> $stable(code_q))
    else $error("code changed without update");

  a_auto_update: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) (word_rdy_q && ld_low) |=> upd_q)
    else $error("auto update missed");

  a_update_pulse: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) (upd_q && !word_rdy_q) |=> !upd_q)
    else $error("update not a pulse");

  a_strobe_load: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) s_strobe_fall |=> s_load_pulse)
    else $error("strobe load missed");

  a_no_early_load: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) !word_rdy_q |=> !upd_q)
    else $error("load before a full word");

  a_capture_word: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) word_evt |=> cap_q == $past(word_q))
    else $error("captured word wrong");

  a_word_ready: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) word_evt |-> s_word_seen)
    else $error("word not marked ready");

  a_take_once: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) (taken_q && done_lvl) |=> taken_q && !word_evt)
    else $error("word taken twice");

  a_frame_rearm: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n) !done_lvl |=> !taken_q)
    else $error("capture not rearmed");

  // link-domain checks
  sequence s_last_bit;
    !i_frame_n && cnt_d == `SDI_CNT_W'(`SDI_WORD_BITS);
  endsequence

  a_shift_in: assert property (@(negedge i_sclk)
    !i_frame_n |=> sh_q[0] == $past(i_serial_in))
    else $error("bit not shifted");

  a_count_start: assert property (@(negedge i_sclk)
    (!i_frame_n && !frame_seen_q) |=> cnt_q == `SDI_CNT_W'(1))
    else $error("bit count not restarted");

  a_count_step: assert property (@(negedge i_sclk)
    (!i_frame_n && frame_seen_q) |=> cnt_q == $past(cnt_q) + `SDI_CNT_W'(1))
    else $error("bit count did not advance");

  a_word_latch: assert property (@(negedge i_sclk)
    s_last_bit |=> word_q == $past(sh_d))
    else $error("word not held at last bit");

  a_frame_idle: assert property (@(negedge i_sclk)
    i_frame_n |=> $stable(sh_q) && $stable(cnt_q))
    else $error("shift while frame high");
endmodule

/* File: src/sdi_cfg.svh */
`ifndef SDI_CFG_SVH
`define SDI_CFG_SVH
`define SDI_WORD_BITS 16
`define SDI_CODE_BITS 12
`define SDI_CNT_W 5
`define SDI_CODE_RST 12'h000
`define SDI_CODE_NEG_FS 12'h800
`define SDI_CODE_POS_FS 12'h7ff
`define SDI_BITCLK_MAX_HZ 5000000
`endif

/* File: src/sdi_pkg.sv */
package sdi_pkg;
  typedef struct packed {
    logic frame_n;
    logic serial_in;
    logic latch_load_n;
  } sdi_pins_s;
  typedef struct packed {
    logic [11:0] code;
    logic neg_fs;
    logic pos_fs;
  } sdi_code_s;
endpackage

/* File: test/sdi_host_model.sv */
`timescale 1ns/1ps
module sdi_host_model (
  output logic o_sclk,
  output logic o_frame_n,
  output logic o_serial_in,
  output logic o_latch_load_n
);
  initial begin
    o_sclk = 1'b1;
    o_frame_n = 1'b0;
    o_serial_in = 1'b0;
    o_latch_load_n = 1'b1;
    // short empty frame at start clears frame_seen_q and done_q in the link logic
    #10 o_frame_n = 1'b1;
  end
  // ld low keeps the strobe tied low for automatic update
  task automatic xfer(input logic [15:0] w, input int n, input logic ld, input int stray);
    o_latch_load_n = ld;
    #20 o_frame_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_in = w[i];
      #62.5 o_sclk = 1'b0;
      #62.5 o_sclk = 1'b1;
    end
    o_serial_in = ~o_serial_in;
    #70 o_frame_n = 1'b1;
    repeat (stray) begin
      #62.5 o_sclk = 1'b0;
      #62.5 o_sclk = 1'b1;
    end
    if (ld) begin
      #20 o_latch_load_n = 1'b0;
      #60 o_latch_load_n = 1'b1;
    end
    #100;
  endtask
endmodule

/* File: test/tb_sdi_serial_dac_input.sv */
`timescale 1ns/1ps
module tb_sdi_serial_dac_input;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic sclk, frame_n, sdata, load_n, o_update;
  sdi_pkg::sdi_code_s o_code;
  int mismatches = 0;
  int checks = 0;
  int updates = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) if (o_update === 1'b1) updates++;
  sdi_host_model i_host (.o_sclk(sclk), .o_frame_n(frame_n), .o_serial_in(sdata),
    .o_latch_load_n(load_n));
  sdi_serial_dac_input i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sclk(sclk),
    .i_frame_n(frame_n), .i_serial_in(sdata), .i_latch_load_n(load_n), .o_code(o_code),
    .o_update(o_update));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // code field then negative and positive full-scale flags
  task automatic run(input logic [15:0] w, input int n, input logic ld, input int stray,
      input logic [13:0] exp, input int nu);
    int u0;
    u0 = updates;
    i_host.xfer(w, n, ld, stray);
    repeat (10) @(negedge i_clk_sys);
    chk(16'(o_code), {2'b00, exp});
    chk(16'(updates - u0), 16'(nu));
  endtask
  task automatic s_strobe(); run(16'ha123, 16, 1, 0, {12'h123, 2'b00}, 1); endtask
  task automatic s_short(); run(16'h00ff, 8, 1, 0, {12'h123, 2'b00}, 0); endtask
  task automatic s_fresh(); run(16'h0555, 16, 1, 0, {12'h555, 2'b00}, 1); endtask
  task automatic s_stray(); run(16'h37ff, 16, 1, 5, {12'h7ff, 2'b01}, 1); endtask
  task automatic s_auto(); run(16'hc800, 16, 0, 0, {12'h800, 2'b10}, 1); endtask
  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    chk(16'(o_code), 16'h0000);
    s_strobe();
    s_short();
    s_fresh();
    s_stray();
    s_auto();
    stop_test();
  end
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule
